// ---- chip_reset_map.svh ----
`ifndef CHIP_RESET_MAP_SVH
`define CHIP_RESET_MAP_SVH
// Software reset control bit location
`define SOFT_RST_WORD      14'h2200
`define SOFT_RST_BIT       3
// Timing
`define PIN_RST_MIN_NS     2000
`define CORE_CLK_NS        25
`define PIN_RST_MIN_CYC    ((`PIN_RST_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define PIN_TIMER_SLOW     4100
`define PIN_TIMER_MS       125
`define SOFT_TIMER_SLOW    16
`define LOWVDD_DELAY_XTAL  4
// Power status code for low core supply
`define PSTAT_LOW_VDD      3'h5
// Boot vector
`define BOOT_ADDR          16'h0000
`endif

// ---- chip_reset_pkg.sv ----
`default_nettype none
package chip_reset_pkg;
  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_HOLD,
    SEQ_TIMING
  } seq_state_t;

  // Reset outputs toward the chip
  typedef struct packed {
    logic digitalHalt;
    logic ioRamReset;
    logic testSelReset;
    logic rtcReset;
    logic cpuReset;
  } rst_out_t;
endpackage : chip_reset_pkg
`default_nettype wire

// ---- chip_reset_sequencer.sv ----
// Operation
// R1 - Pin reset high halts digital logic; oscillator and real-time clock keep running.
// R2 - Pin reset forces all I/O RAM bits to reset values.
// R3 - Outside party holds pin reset high for at least 2 us.
// R4 - Test selector and clock reset by pin only when test pin also high.
// R5 - Software reset bit at word 2200 bit 3 resets like pin, shorter timer.
// R6 - After full reset, hold until timer expires; pin timer is 4100 slow cycles.
// R7 - On timer expiry release processor to boot from address 0x0000.
// R8 - Debug port reset low resets only the processor core.
// R9 - Debug port reset skips the timer; processor restarts at once.
// R10 - Power status code 101 causes a reset four crystal cycles later.
// R11 - Software reset timer length is a parameter in slow engine cycles.
`include "chip_reset_map.svh"
`default_nettype none
module chip_reset_sequencer #(
  parameter int PIN_TIMER  = `PIN_TIMER_SLOW,
  parameter int SOFT_TIMER = `SOFT_TIMER_SLOW,
  parameter int PIN_MIN    = `PIN_RST_MIN_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    resetPin,
  input  wire logic                    testPin,
  input  wire logic                    debugResetPin_n,
  input  wire logic                    slowEngineClock,
  input  wire logic                    crystalClockSlow,
  input  wire logic [2:0]              powerStatusField,
  input  wire logic                    ioWrite,
  input  wire logic [13:0]             ioAddr,
  input  wire logic [7:0]              ioWdata,
  output var  chip_reset_pkg::rst_out_t rstOut,
  output logic [15:0]                  bootAddr,
  output logic                         bootStart
);
  // =========================================================
  // Shared helpers
  // True once a reset timer has run down to zero
  function automatic logic timerDone(input logic [15:0] count);
    return count == 16'h0000;
  endfunction : timerDone

  // =========================================================
  // Input synchronisers
  // Every pin from outside the core clock domain passes two flip-flops
  logic [1:0] pinSync;
  logic [1:0] testSync;
  logic [1:0] dbgSync;
  logic [1:0] slowSync;
  logic [1:0] xtalSync;
  logic       slowPrev;
  logic       xtalPrev;
  logic       slowTick;
  logic       xtalTick;

  // Reset, test and debug pins; the debug pin idles high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync  <= 2'h0;
      testSync <= 2'h0;
      dbgSync  <= 2'h3;
    end else begin
      pinSync  <= {pinSync[0], resetPin};
      testSync <= {testSync[0], testPin};
      dbgSync  <= {dbgSync[0], debugResetPin_n};
    end
  end

  // Slow engine and crystal clocks sampled as plain data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slowSync <= 2'h0;
      xtalSync <= 2'h0;
    end else begin
      slowSync <= {slowSync[0], slowEngineClock};
      xtalSync <= {xtalSync[0], crystalClockSlow};
    end
  end

  // Last synchronised level; only the second flip-flop is read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slowPrev <= 1'b0;
      xtalPrev <= 1'b0;
    end else begin
      slowPrev <= slowSync[1];
      xtalPrev <= xtalSync[1];
    end
  end

  // One-cycle ticks on rising slow clock edges
  assign slowTick = slowSync[1] & ~slowPrev;
  assign xtalTick = xtalSync[1] & ~xtalPrev;

  // =========================================================
  // Pin qualification: count high time before a reset is taken
  // Pulses shorter than the minimum width cannot start a reset; SEQ_HOLD and the test latch read the synchronised, unqualified pin
  logic [15:0] pinCnt_ff;
  logic        pinValid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinCnt_ff <= 16'h0000;
    end else if (!pinSync[1]) begin
      pinCnt_ff <= 16'h0000;
    end else if (pinCnt_ff < 16'(PIN_MIN)) begin
      pinCnt_ff <= pinCnt_ff + 16'h0001;
    end
  end
  assign pinValid = pinSync[1] && (pinCnt_ff >= 16'(PIN_MIN)); // R3

  // =========================================================
  // Software reset bit write decode
  // Taken only while running; the sequencer ignores it during a reset
  logic softReq;
  assign softReq = ioWrite && (ioAddr == `SOFT_RST_WORD) && ioWdata[`SOFT_RST_BIT]; // R5

  // =========================================================
  // Low supply: reset after four crystal cycles
  // Counter restarts whenever the status code leaves the low-supply value
  logic [2:0] lowCnt_ff;
  logic       lowReq;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_ff <= 3'h0;
    end else if (powerStatusField != `PSTAT_LOW_VDD) begin
      lowCnt_ff <= 3'h0;
    end else if (xtalTick && lowCnt_ff < 3'(`LOWVDD_DELAY_XTAL)) begin
      lowCnt_ff <= lowCnt_ff + 3'h1; // R10
    end
  end
  assign lowReq = (lowCnt_ff == 3'(`LOWVDD_DELAY_XTAL)); // R10

  // =========================================================
  // Full reset request: pin and low supply both use the long timer
  logic fullReq;
  assign fullReq = pinValid || lowReq;

  // =========================================================
  // Sequencer state and timer
  chip_reset_pkg::seq_state_t state_ff;
  logic [15:0] timer_ff;
  logic        testLatched_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= chip_reset_pkg::SEQ_HOLD;
      timer_ff <= 16'(PIN_TIMER);
    end else begin
      unique case (state_ff)
        chip_reset_pkg::SEQ_RUN: begin
          if (pinValid || lowReq) begin
            state_ff <= chip_reset_pkg::SEQ_HOLD;
            timer_ff <= 16'(PIN_TIMER); // R6
          end else if (softReq) begin
            state_ff <= chip_reset_pkg::SEQ_TIMING;
            timer_ff <= 16'(SOFT_TIMER); // R11
          end
        end
        chip_reset_pkg::SEQ_HOLD: begin
          // Hold while pin or low supply persists
          if (!pinSync[1] && !lowReq) begin
            state_ff <= chip_reset_pkg::SEQ_TIMING;
          end
        end
        chip_reset_pkg::SEQ_TIMING: begin
          if (pinValid || lowReq) begin
            state_ff <= chip_reset_pkg::SEQ_HOLD;
            timer_ff <= 16'(PIN_TIMER);
          end else if (timerDone(timer_ff)) begin
            state_ff <= chip_reset_pkg::SEQ_RUN; // R7
          end else if (slowTick) begin
            timer_ff <= timer_ff - 16'h0001; // R6
          end
        end
        default: begin
          // An unused state code falls back to a full timed reset
          state_ff <= chip_reset_pkg::SEQ_HOLD;
          timer_ff <= 16'(PIN_TIMER);
        end
      endcase
    end
  end

  // Test pin seen during pin reset widens its scope
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      testLatched_ff <= 1'b0;
    end else if (state_ff == chip_reset_pkg::SEQ_RUN) begin
      testLatched_ff <= 1'b0;
    end else if (pinSync[1] && testSync[1]) begin
      testLatched_ff <= 1'b1; // R4
    end
  end

  // =========================================================
  // Registered outputs
  // Reset lines follow the sequencer state one cycle later
  logic inReset;
  assign inReset = (state_ff != chip_reset_pkg::SEQ_RUN);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstOut <= '{default: 1'b1};
    end else begin
      rstOut.digitalHalt  <= inReset;                   // R1
      rstOut.ioRamReset   <= inReset;                   // R2
      rstOut.testSelReset <= inReset && testLatched_ff; // R4
      rstOut.rtcReset     <= inReset && testLatched_ff; // R1 R4
      rstOut.cpuReset     <= inReset || !dbgSync[1];    // R8 R9
    end
  end

  // Boot vector, fixed at the start of program space
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bootAddr <= `BOOT_ADDR;
    end else begin
      bootAddr <= `BOOT_ADDR; // R7
    end
  end

  // Boot strobe one cycle after the last timed cycle, unless a new full request cuts it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bootStart <= 1'b0;
    end else begin
      bootStart <= (state_ff == chip_reset_pkg::SEQ_TIMING) && timerDone(timer_ff)
                   && !fullReq; // R7
    end
  end
endmodule : chip_reset_sequencer
`default_nettype wire

// ---- chip_reset_sequencer_properties.sv ----
`default_nettype none
// ====
// Checks on sequencer ports
module chip_reset_sequencer_properties (
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  input wire logic                     debugResetPin_n,
  input wire logic                     ioWrite,
  input wire logic [13:0]              ioAddr,
  input wire logic [7:0]               ioWdata,
  input wire chip_reset_pkg::rst_out_t rstOut,
  input wire logic [15:0]              bootAddr,
  input wire logic                     bootStart
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_boot_vector: assert property (bootAddr == 16'h0000)
    else $error("boot vector");
  chk_boot_after_hold: assert property (bootStart |-> $past(rstOut.digitalHalt))
    else $error("boot without hold");
  chk_boot_releases: assert property (
    bootStart |=> !rstOut.digitalHalt && !rstOut.ioRamReset) else $error("no release");
  chk_ram_with_halt: assert property (rstOut.ioRamReset == rstOut.digitalHalt)
    else $error("ram reset split");
  chk_test_sel_pair: assert property (
    rstOut.testSelReset |-> rstOut.rtcReset && rstOut.digitalHalt) else $error("test sel");
  chk_debug_local: assert property (
    !rstOut.digitalHalt |-> !rstOut.rtcReset && !rstOut.testSelReset) else $error("local");
  chk_debug_cpu: assert property (!debugResetPin_n [*5] |-> rstOut.cpuReset)
    else $error("debug cpu");
  chk_debug_no_timer: assert property ($rose(debugResetPin_n) |->
    ##[1:6] (!rstOut.cpuReset || rstOut.digitalHalt)) else $error("debug held");
  chk_soft_start: assert property (ioWrite && ioAddr == 14'h2200 && ioWdata[3] &&
    !rstOut.digitalHalt |-> ##[1:3] rstOut.digitalHalt) else $error("soft reset");
endmodule : chip_reset_sequencer_properties
bind chip_reset_sequencer chip_reset_sequencer_properties i_chip_reset_sequencer_properties (
  .core_clk, .rst_n, .debugResetPin_n, .ioWrite, .ioAddr, .ioWdata, .rstOut, .bootAddr,
  .bootStart);
`default_nettype wire

// ---- reset_source_model.sv ----
`default_nettype none
// ====
// Reset pin source and slow clocks
module reset_source_model (
  input  wire logic core_clk,
  output logic      resetPin,
  output logic      slowEngineClock,
  output logic      crystalClockSlow
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  initial {resetPin, slowEngineClock, crystalClockSlow} = 3'h0;
  // Clocks divided down from the core clock
  always @(negedge core_clk) begin
    phase <= phase + 1;
    slowEngineClock <= phase[2];
    crystalClockSlow <= (phase % 6) < 3;
  end
  // Pin pulse held past the reliable width
  task automatic pulse(input int cycles);
    resetPin = 1'b1;
    repeat (cycles) @(negedge core_clk);
    resetPin = 1'b0;
  endtask : pulse
endmodule : reset_source_model
`default_nettype wire

// ---- tb_chip_reset_sequencer.sv ----
`default_nettype none
`define CHECK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_chip_reset_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst_n = 0, testPin = 0, debugResetPin_n = 1, ioWrite = 0;
  logic resetPin, slowEngineClock, crystalClockSlow, bootStart;
  logic [2:0]  powerStatusField = 3'h0;
  logic [13:0] ioAddr = 14'h0000;
  logic [7:0]  ioWdata = 8'h00;
  logic [15:0] bootAddr;
  logic [15:0] expected[$];
  chip_reset_pkg::rst_out_t rstOut;
  int errors = 0, samplesChecked = 0;
  int waited;
  logic [15:0] note;
  // Shortened timers, and the slow clock period that the partner model makes
  localparam int PIN_T = 8;
  localparam int SOFT_T = 3;
  localparam int SLOW_DIV = 8;
  chip_reset_sequencer #(.PIN_TIMER(PIN_T), .SOFT_TIMER(SOFT_T))
    i_chip_reset_sequencer (.core_clk,
    .rst_n, .resetPin, .testPin, .debugResetPin_n, .slowEngineClock, .crystalClockSlow,
    .powerStatusField, .ioWrite, .ioAddr, .ioWdata, .rstOut, .bootAddr, .bootStart);
  reset_source_model i_reset_source_model (.core_clk, .resetPin, .slowEngineClock,
    .crystalClockSlow);
  always #12.5 core_clk = ~core_clk;
  // Each boot pulse retires the oldest note
  always @(negedge core_clk) begin
    if (bootStart === 1'b1) begin
      if (expected.size() == 0) `CHECK(bootStart, 1'b0)
      else begin
        note = expected.pop_front();
        `CHECK(bootAddr, note)
      end
    end
  end
  task automatic bootWait(output int cycles);
    expected.push_back(16'h0000);
    cycles = 0;
    while (cycles < 600 && bootStart !== 1'b1) begin
      @(negedge core_clk);
      cycles++;
    end
    @(negedge core_clk);
  endtask : bootWait
  task automatic testDone;
    if (expected.size() != 0) errors++;
    if (errors == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : testDone
  // Scenarios: power-on, pin, soft, debug, low supply
  initial begin
    void'($urandom(86901));
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    bootWait(waited);
    `CHECK(waited >= (PIN_T - 2) * SLOW_DIV, 1'b1)
    for (int t = 0; t < 2; t++) begin
      testPin = t[0];
      fork i_reset_source_model.pulse(100 + $urandom % 40); join_none
      repeat (90) @(negedge core_clk);
      `CHECK(rstOut.digitalHalt, 1'b1)
      `CHECK(rstOut, {2'h3, t[0], t[0], 1'b1})
      wait (resetPin === 1'b0);
      testPin = 0;
      bootWait(waited);
      `CHECK(waited >= (PIN_T - 2) * SLOW_DIV, 1'b1)
    end
    ioWrite = 1;
    ioAddr = 14'h2200;
    ioWdata = 8'($urandom) & 8'hf7;
    @(negedge core_clk);
    ioWdata = 8'($urandom) | 8'h08;
    @(negedge core_clk);
    ioWrite = 0;
    repeat (3) @(negedge core_clk);
    `CHECK(rstOut, 5'h19)
    bootWait(waited);
    `CHECK(waited <= (SOFT_T + 1) * SLOW_DIV, 1'b1)
    debugResetPin_n = 0;
    repeat (8) @(negedge core_clk);
    `CHECK(rstOut, 5'h01)
    debugResetPin_n = 1;
    repeat (6) @(negedge core_clk);
    `CHECK(rstOut, 5'h00)
    powerStatusField = 3'h5;
    repeat (10) @(negedge core_clk);
    `CHECK(rstOut.digitalHalt, 1'b0)
    repeat (30) @(negedge core_clk);
    `CHECK(rstOut, 5'h19)
    powerStatusField = 3'h2;
    bootWait(waited);
    `CHECK(waited >= (PIN_T - 2) * SLOW_DIV, 1'b1)
    testDone();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    errors++;
    testDone();
  end
endmodule : tb_chip_reset_sequencer
`default_nettype wire
